// file: hw/psr_pkg.sv
// constants and types shared by the status and sequencing register bank
package psr_pkg;

   // =====================================================================
   // command codes
   localparam logic [7:0] CMD_CLEAR_FAULTS   = 8'h03;
   localparam logic [7:0] CMD_STATUS_BYTE    = 8'h78;
   localparam logic [7:0] CMD_STATUS_WORD    = 8'h79;
   localparam logic [7:0] CMD_OUTPUT_VOLTAGE_STATUS    = 8'h7A;
   localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS    = 8'h7B;
   localparam logic [7:0] CMD_STATUS_INPUT   = 8'h7C;

   // =====================================================================
   // read/write configuration words
   localparam int          CFG_COUNT = 5;
   localparam int          CFG_PG    = 0;
   localparam int          CFG_TOND  = 1;
   localparam int          CFG_TONR  = 2;
   localparam int          CFG_TOFFD = 3;
   localparam int          CFG_TOFFF = 4;
   localparam logic [15:0] WORD_RESET  = 16'h0000;
   localparam logic [15:0] DELAY_RESET = 16'hCA80;
   localparam logic [15:0] RAMP_RESET  = 16'hD280;
   localparam logic [7:0]  CFG_CMD [CFG_COUNT] =
      '{8'h5E, 8'h60, 8'h61, 8'h64, 8'h65};
   localparam logic [15:0] CFG_RESET [CFG_COUNT] =
      '{WORD_RESET, DELAY_RESET, RAMP_RESET, DELAY_RESET, RAMP_RESET};

   // power-good default is 9/10 of the strapped setpoint
   localparam logic [19:0] PG_NUM = 20'h00009;
   localparam logic [19:0] PG_DEN = 20'h0000A;

   // =====================================================================
   // status layout
   localparam logic [7:0] BYTE_RESET  = 8'h00;
   localparam logic [7:0] DETAIL_MASK = 8'hF0;
   localparam logic [7:0] IOUT_MASK   = 8'hD0;
   localparam int SB_BUSY  = 7;
   localparam int SB_OFF   = 6;
   localparam int SB_VOOV  = 5;
   localparam int SB_IOOC  = 4;
   localparam int SB_VINUV = 3;
   localparam int SB_TEMP  = 2;
   localparam int SB_CML   = 1;
   localparam int SB_OTHER = 0;
   localparam int SW_VOUT  = 15;
   localparam int SW_IOUT  = 14;
   localparam int SW_INPUT = 13;
   localparam int SW_PG_N  = 11;

   typedef enum logic [1:0] {
      ST_RESET  = 2'b00,
      ST_SETTLE = 2'b01,
      ST_RUN    = 2'b11
   } psr_strap_e;

   typedef struct packed {
      logic       ov_fault;
      logic       ov_warn;
      logic       uv_warn;
      logic       uv_fault;
      logic [3:0] unused;
   } psr_volt_stat_s;

   typedef struct packed {
      logic       oc_fault;
      logic       overcurrent_low_voltage_fault;
      logic       reserved;
      logic       uc_fault;
      logic [3:0] unused;
   } psr_curr_stat_s;

   typedef struct packed {
      psr_volt_stat_s vout;
      psr_curr_stat_s iout;
      psr_volt_stat_s vin;
      logic           temp_event;
      logic           comms_memory_logic_flag;
      logic           maker_specific_flag;
      logic           fan_event;
      logic           other_status;
      logic           unknown_event;
   } psr_event_s;

   typedef struct packed {
      logic        write;
      logic [7:0]  cmd;
      logic [15:0] wdata;
   } psr_access_s;

endpackage

// file: hw/psr_regs.sv
// status and sequencing command-register bank with transport-clock handshake
// =====================================================================
// Overview of operation
// - power good rises above threshold, falls only below undervoltage limit
// - threshold word read/write, defaults to 0.9 of strapped setpoint
// - turn-on delay word, enable to start of rise, default 5 ms
// - rise time word, ramp-up length, default 10 ms
// - turn-off delay word, disable to start of fall, default 5 ms
// - fall time word, ramp-down length, default 10 ms
// - timing words read/write; delays reset CA80h, ramps D280h
// - status byte storage zero after reset; bit 7 flags busy refusal
// - status bit 6 set whenever output is not powered
// - bits 5,4,3 flag output overvoltage, overcurrent, input undervoltage
// - bit 2 temperature event, bit 1 comms, memory or logic fault
// - bit 0 flags the detail-byte events not covered by bits 5 to 3
// - status word storage zero after reset, bit 11 reads set until power good; low byte is the status byte storage
// - word bits 15..12: output voltage, current, input, maker events
// - word bit 11 set while power good is negated
// - bit 10 fan, bit 9 other status, bit 8 unknown fault
// - output voltage byte: ov fault, ov warn, uv warn, uv fault
// - current byte: overcurrent, overcurrent low voltage, undercurrent
// - input byte: ov fault, ov warn, uv warn, uv fault
// - fault bits stay set until the clear-faults command
// - input warning sets other bit, input bit, warning bit, alerts host
`timescale 1ns/1ps
`default_nettype none

module psr_regs (
   input  wire logic                 clk,             // core clock
   input  wire logic                 rst,             // core sync reset
   input  wire logic                 lk_clk,          // transport clock
   input  wire logic                 lk_rst,          // transport sync reset
   input  wire logic                 lk_req,          // access request pulse
   input  wire psr_pkg::psr_access_s lk_acc,          // access with lk_req
   output logic                      lk_busy,         // access in flight
   output logic                      lk_done,         // access finished pulse
   output logic [15:0]               lk_rdata,        // read data at lk_done
   input  wire logic [15:0]          strap_setpoint,  // setpoint pin strap
   input  wire logic                 output_powered,  // regulator is powering
   input  wire logic [15:0]          vout_code,       // measured output
   input  wire logic [15:0]          output_undervoltage_limit, // uv limit
   input  wire psr_pkg::psr_event_s  ev,              // monitor event pulses
   output logic                      power_good,      // power good level
   output logic                      host_alert,      // any sticky flag set
   output logic [15:0]               power_good_threshold, // threshold word
   output logic [15:0]               turn_on_delay,   // delay word
   output logic [15:0]               turn_on_rise_time, // rise word
   output logic [15:0]               turn_off_delay,  // delay word
   output logic [15:0]               turn_off_fall_time // fall word
);

   // =====================================================================
   // transport side: capture, hold, and return
   logic                 req_tgl;
   logic                 busy_tgl;
   psr_pkg::psr_access_s acc_q;
   logic                 ack_s1;
   logic                 ack_s2;
   logic                 ack_s3;
   logic                 ack_tgl;
   logic [15:0]          rd_q;

   wire logic lk_take   = lk_req && !lk_busy;
   wire logic lk_refuse = lk_req && lk_busy;
   wire logic ack_edge  = ack_s2 ^ ack_s3;

   // request data is frozen until the answer returns, so the core may
   // read acc_q directly once the toggle has been synchronised
   always_ff @(posedge lk_clk) begin
      if (lk_rst) begin
         req_tgl <= 1'b0;
         acc_q   <= '0;
      end else if (lk_take) begin
         req_tgl <= ~req_tgl;
         acc_q   <= lk_acc;
      end
   end

   always_ff @(posedge lk_clk) begin
      if (lk_rst) begin
         lk_busy <= 1'b0;
      end else if (lk_take) begin
         lk_busy <= 1'b1;
      end else if (ack_edge) begin
         lk_busy <= 1'b0;
      end
   end

   // a request while busy is dropped and reported as a busy fault
   always_ff @(posedge lk_clk) begin
      if (lk_rst) begin
         busy_tgl <= 1'b0;
      end else if (lk_refuse) begin
         busy_tgl <= ~busy_tgl;
      end
   end

   always_ff @(posedge lk_clk) begin
      if (lk_rst) begin
         ack_s1 <= 1'b0;
         ack_s2 <= 1'b0;
         ack_s3 <= 1'b0;
      end else begin
         ack_s1 <= ack_tgl;
         ack_s2 <= ack_s1;
         ack_s3 <= ack_s2;
      end
   end

   always_ff @(posedge lk_clk) begin
      if (lk_rst) begin
         lk_done  <= 1'b0;
         lk_rdata <= psr_pkg::WORD_RESET;
      end else begin
         lk_done <= ack_edge;
         if (ack_edge) begin
            lk_rdata <= rd_q;
         end
      end
   end

   // =====================================================================
   // core side synchronisers
   logic req_s1;
   logic req_s2;
   logic req_s3;
   logic bsy_s1;
   logic bsy_s2;
   logic bsy_s3;

   always_ff @(posedge clk) begin
      if (rst) begin
         req_s1 <= 1'b0;
         req_s2 <= 1'b0;
         req_s3 <= 1'b0;
         bsy_s1 <= 1'b0;
         bsy_s2 <= 1'b0;
         bsy_s3 <= 1'b0;
      end else begin
         req_s1 <= req_tgl;
         req_s2 <= req_s1;
         req_s3 <= req_s2;
         bsy_s1 <= busy_tgl;
         bsy_s2 <= bsy_s1;
         bsy_s3 <= bsy_s2;
      end
   end

   wire logic core_go = req_s2 ^ req_s3;
   wire logic busy_ev = bsy_s2 ^ bsy_s3;
   wire logic core_wr = core_go && acc_q.write;
   wire logic core_rd = core_go && !acc_q.write;

   // =====================================================================
   // command decode
   function automatic logic is_rw_reg(input logic [7:0] c);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < psr_pkg::CFG_COUNT; i++) begin
         hit = hit | (c == psr_pkg::CFG_CMD[i]);
      end
      return hit;
   endfunction

   function automatic logic is_ro_reg(input logic [7:0] c);
      return c inside {psr_pkg::CMD_STATUS_BYTE, psr_pkg::CMD_STATUS_WORD,
                       psr_pkg::CMD_OUTPUT_VOLTAGE_STATUS, psr_pkg::CMD_OUTPUT_CURRENT_STATUS,
                       psr_pkg::CMD_STATUS_INPUT};
   endfunction

   function automatic logic [15:0] sticky(input logic [15:0] old,
                                          input logic [15:0] set,
                                          input logic        clr);
      return clr ? set : (old | set);
   endfunction

   wire logic clear_cmd = core_wr && (acc_q.cmd == psr_pkg::CMD_CLEAR_FAULTS);
   wire logic cmd_ok    = is_rw_reg(acc_q.cmd) || is_ro_reg(acc_q.cmd)
                          || (acc_q.write && (acc_q.cmd == psr_pkg::CMD_CLEAR_FAULTS));
   // unknown commands and writes to status count as comms faults
   wire logic bad_acc   = core_go && (!cmd_ok || (acc_q.write && is_ro_reg(acc_q.cmd)));

   // =====================================================================
   // strap capture for the power-good default
   logic [15:0]         strap_s1;
   logic [15:0]         strap_s2;
   psr_pkg::psr_strap_e strap_st;
   psr_pkg::psr_strap_e next_strap_st;

   always_ff @(posedge clk) begin
      strap_s1 <= strap_setpoint;
      strap_s2 <= strap_s1;
   end

   wire logic [19:0] pg_scaled = ({4'h0, strap_s2} * psr_pkg::PG_NUM) / psr_pkg::PG_DEN;
   wire logic [15:0] pg_default = pg_scaled[15:0];

   always_comb begin
      case (strap_st)
         psr_pkg::ST_RESET:  next_strap_st = psr_pkg::ST_SETTLE;
         psr_pkg::ST_SETTLE: next_strap_st = psr_pkg::ST_RUN;
         psr_pkg::ST_RUN:    next_strap_st = psr_pkg::ST_RUN;
         default:            next_strap_st = psr_pkg::ST_RESET;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         strap_st <= psr_pkg::ST_RESET;
      end else begin
         strap_st <= next_strap_st;
      end
   end

   // =====================================================================
   // configuration words
   logic [15:0] cfg [psr_pkg::CFG_COUNT];

   for (genvar i = 0; i < psr_pkg::CFG_COUNT; i++) begin : g_cfg
      wire logic hit = core_wr && (acc_q.cmd == psr_pkg::CFG_CMD[i]);
      always_ff @(posedge clk) begin
         if (rst) begin
            cfg[i] <= psr_pkg::CFG_RESET[i];
         end else if (hit) begin
            cfg[i] <= acc_q.wdata;
         end else if (i == psr_pkg::CFG_PG && strap_st == psr_pkg::ST_SETTLE) begin
            cfg[i] <= pg_default;
         end
      end
   end

   assign power_good_threshold = cfg[psr_pkg::CFG_PG];
   assign turn_on_delay        = cfg[psr_pkg::CFG_TOND];
   assign turn_on_rise_time    = cfg[psr_pkg::CFG_TONR];
   assign turn_off_delay       = cfg[psr_pkg::CFG_TOFFD];
   assign turn_off_fall_time   = cfg[psr_pkg::CFG_TOFFF];

   // =====================================================================
   // power good with hysteresis; held low until the threshold is loaded
   wire logic pg_rise = vout_code > power_good_threshold;
   wire logic pg_fall = vout_code < output_undervoltage_limit;

   always_ff @(posedge clk) begin
      if (rst) begin
         power_good <= 1'b0;
      end else if (strap_st != psr_pkg::ST_RUN) begin
         power_good <= 1'b0;
      end else if (pg_rise) begin
         power_good <= 1'b1;
      end else if (pg_fall) begin
         power_good <= 1'b0;
      end
   end

   // =====================================================================
   // sticky status; a set in the clearing cycle survives the clear
   logic [7:0]  st_vout;
   logic [7:0]  st_iout;
   logic [7:0]  st_input;
   logic [15:0] st_word;
   logic [15:0] live_word;

   wire logic [7:0] set_vout  = ev.vout & psr_pkg::DETAIL_MASK;
   wire logic [7:0] set_iout  = ev.iout & psr_pkg::IOUT_MASK;
   wire logic [7:0] set_input = ev.vin & psr_pkg::DETAIL_MASK;
   wire logic cml_set   = ev.comms_memory_logic_flag || bad_acc;
   wire logic other_set = ev.vin.ov_warn || ev.vin.uv_warn || ev.vin.ov_fault
                          || ev.vout.ov_warn || ev.vout.uv_warn || ev.vout.uv_fault
                          || ev.iout.overcurrent_low_voltage_fault
                          || ev.iout.uc_fault;

   // bits 11 and 6 are live levels, so they are never stored
   wire logic [15:0] set_word = {|set_vout, |set_iout, |set_input,
                                 ev.maker_specific_flag, 1'b0,
                                 ev.fan_event, ev.other_status, ev.unknown_event,
                                 busy_ev, 1'b0,
                                 ev.vout.ov_fault, ev.iout.oc_fault, ev.vin.uv_fault,
                                 ev.temp_event, cml_set, other_set};

   wire logic [15:0] next_word  = sticky(st_word, set_word, clear_cmd);
   wire logic [15:0] next_vout  = sticky({8'h00, st_vout}, {8'h00, set_vout}, clear_cmd);
   wire logic [15:0] next_iout  = sticky({8'h00, st_iout}, {8'h00, set_iout}, clear_cmd);
   wire logic [15:0] next_input = sticky({8'h00, st_input}, {8'h00, set_input}, clear_cmd);

   // status registers change only through events and clear, never by write
   always_ff @(posedge clk) begin
      if (rst) begin
         st_word  <= psr_pkg::WORD_RESET;
         st_vout  <= psr_pkg::BYTE_RESET;
         st_iout  <= psr_pkg::BYTE_RESET;
         st_input <= psr_pkg::BYTE_RESET;
      end else begin
         st_word  <= next_word;
         st_vout  <= next_vout[7:0];
         st_iout  <= next_iout[7:0];
         st_input <= next_input[7:0];
      end
   end

   always_comb begin
      live_word                   = st_word;
      live_word[psr_pkg::SB_OFF]  = !output_powered;
      live_word[psr_pkg::SW_PG_N] = !power_good;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         host_alert <= 1'b0;
      end else begin
         host_alert <= |{next_word, next_vout, next_iout, next_input};
      end
   end

   // =====================================================================
   // read answer
   logic [15:0] next_rdata;

   always_comb begin
      next_rdata = psr_pkg::WORD_RESET;
      for (int i = 0; i < psr_pkg::CFG_COUNT; i++) begin
         if (acc_q.cmd == psr_pkg::CFG_CMD[i]) begin
            next_rdata = cfg[i];
         end
      end
      case (acc_q.cmd)
         psr_pkg::CMD_STATUS_BYTE:  next_rdata = {8'h00, live_word[7:0]};
         psr_pkg::CMD_STATUS_WORD:  next_rdata = live_word;
         psr_pkg::CMD_OUTPUT_VOLTAGE_STATUS:  next_rdata = {8'h00, st_vout};
         psr_pkg::CMD_OUTPUT_CURRENT_STATUS:  next_rdata = {8'h00, st_iout};
         psr_pkg::CMD_STATUS_INPUT: next_rdata = {8'h00, st_input};
         default: ;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_q    <= psr_pkg::WORD_RESET;
         ack_tgl <= 1'b0;
      end else if (core_go) begin
         rd_q    <= core_rd ? next_rdata : psr_pkg::WORD_RESET;
         ack_tgl <= ~ack_tgl;
      end
   end

   // =====================================================================
   // checks
   sequence seq_taken;
      lk_req && !lk_busy;
   endsequence

   sequence seq_answered;
      ##[3:6] lk_done;
   endsequence

   chk_link_answer:
   assert property (@(posedge lk_clk) disable iff (lk_rst) seq_taken |-> seq_answered)
      else $error("access not answered in time");

   chk_pg_rise:
   assert property (@(posedge clk) disable iff (rst)
      (strap_st == psr_pkg::ST_RUN && pg_rise) |=> power_good)
      else $error("power good did not rise");

   chk_pg_hold:
   assert property (@(posedge clk) disable iff (rst)
      (power_good && !pg_fall) |=> power_good)
      else $error("power good dropped above uv limit");

   chk_pg_default:
   assert property (@(posedge clk) disable iff (rst)
      (strap_st == psr_pkg::ST_SETTLE && !core_wr) |=>
      power_good_threshold == $past(pg_default))
      else $error("threshold default wrong");

   chk_seq_defaults:
   assert property (@(posedge clk) disable iff (rst)
      $fell(rst) |-> (turn_on_delay == psr_pkg::DELAY_RESET
                      && turn_on_rise_time == psr_pkg::RAMP_RESET
                      && turn_off_delay == psr_pkg::DELAY_RESET
                      && turn_off_fall_time == psr_pkg::RAMP_RESET
                      && st_word == psr_pkg::WORD_RESET))
      else $error("reset values wrong");

   chk_off_read:
   assert property (@(posedge clk) disable iff (rst)
      (core_rd && acc_q.cmd == psr_pkg::CMD_STATUS_BYTE) |=>
      (rd_q[psr_pkg::SB_OFF] == !$past(output_powered) && rd_q[15:8] == 8'h00))
      else $error("off bit or byte read wrong");

   chk_pg_flag:
   assert property (@(posedge clk) disable iff (rst)
      (core_rd && acc_q.cmd == psr_pkg::CMD_STATUS_WORD) |=>
      rd_q[psr_pkg::SW_PG_N] == !$past(power_good))
      else $error("power good flag wrong");

   chk_sticky_hold:
   assert property (@(posedge clk) disable iff (rst)
      (st_word[psr_pkg::SB_VOOV] && !clear_cmd) |=> st_word[psr_pkg::SB_VOOV])
      else $error("fault bit lost without clear");

   chk_set_wins:
   assert property (@(posedge clk) disable iff (rst)
      (clear_cmd && ev.iout.oc_fault) |=>
      (st_word[psr_pkg::SB_IOOC] && st_word[psr_pkg::SW_IOUT] && st_iout[7]))
      else $error("event lost in clearing cycle");

   chk_input_warn:
   assert property (@(posedge clk) disable iff (rst)
      ev.vin.uv_warn |=> (st_word[psr_pkg::SB_OTHER] && st_word[psr_pkg::SW_INPUT]
                          && st_input[5]) ##1 host_alert)
      else $error("input warning not reported");

   chk_ro_write:
   assert property (@(posedge clk) disable iff (rst)
      (core_wr && acc_q.cmd == psr_pkg::CMD_OUTPUT_VOLTAGE_STATUS && set_vout == 8'h00)
      |=> (st_vout == $past(st_vout) && st_word[psr_pkg::SB_CML]))
      else $error("read-only status changed by write");

endmodule

`default_nettype wire

// file: tb/psr_host.sv
// host-side model of the transport access handshake
`timescale 1ns/1ps
`default_nettype none

module psr_host (
   input  wire logic            lk_clk,   // transport clock
   output logic                 lk_req,   // request pulse
   output psr_pkg::psr_access_s lk_acc,   // access fields
   input  wire logic            lk_busy,  // access in flight
   input  wire logic            lk_done,  // answer pulse
   input  wire logic [15:0]     lk_rdata  // read data
);
   // =====================================================================
   // access task
   initial begin
      lk_req = 1'b0;
      lk_acc = '0;
   end

   // dup repeats the request on the busy edge, which must be refused
   task automatic access(input logic w, input logic [7:0] c, input logic [15:0] d,
                         input bit dup, output logic [15:0] q, output bit ok);
      @(posedge lk_clk);
      lk_req <= 1'b1;
      lk_acc <= '{w, c, d};
      @(posedge lk_clk);
      lk_req <= dup;
      ok = 1'b0;
      for (int n = 0; n < 9 && !ok; n++) begin
         @(posedge lk_clk);
         lk_req <= 1'b0;
         // fields no longer qualified: keep them moving
         lk_acc <= psr_pkg::psr_access_s'(~lk_acc);
         ok = lk_done;
         q = lk_rdata;
      end
   endtask
endmodule

`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the status and sequencing register bank
`timescale 1ns/1ps
`default_nettype none

module testbench;
   logic                 clk = 1'b0;
   logic                 lk_clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 lk_rst = 1'b1;
   logic                 lk_req, lk_busy, lk_done, pg, alert;
   logic                 powered = 1'b1;
   psr_pkg::psr_access_s lk_acc;
   psr_pkg::psr_event_s  ev = '0;
   logic [15:0]          lk_rdata, q, strap, v;
   logic [15:0]          vcode = 16'h0000;
   logic [15:0]          uvl = 16'h0000;
   logic [15:0]          cfg [5];
   int                   error_cnt = 0, comparisons = 0, cyc = 0, thr;
   int                   seed = 32'h62FE;
   int                   pv [3];
   bit                   exp_pg = 1'b0;
   // event bit, summary word, detail command, detail value
   int          ix [11] = '{29, 21, 11, 10, 20, 5, 4, 3, 2, 1, 0};
   logic [15:0] wd [11] = '{16'h8020, 16'h4010, 16'h2001, 16'h2008, 16'h4001, 16'h0004,
                            16'h0002, 16'h1000, 16'h0400, 16'h0200, 16'h0100};
   logic [7:0]  dc [11] = '{8'h7A, 8'h7B, 8'h7C, 8'h7C, 8'h7B, 8'h78, 8'h78, 8'h78, 8'h78,
                            8'h78, 8'h78};
   logic [15:0] dv [11] = '{16'h0080, 16'h0080, 16'h0020, 16'h0010, 16'h0040, 16'h0004,
                            16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

   always #5 clk = ~clk;
   always #62.5 lk_clk = ~lk_clk;

   psr_regs dut_u (
      .clk(clk), .rst(rst), .lk_clk(lk_clk), .lk_rst(lk_rst), .lk_req(lk_req),
      .lk_acc(lk_acc), .lk_busy(lk_busy), .lk_done(lk_done), .lk_rdata(lk_rdata),
      .strap_setpoint(strap), .output_powered(powered), .vout_code(vcode),
      .output_undervoltage_limit(uvl), .ev(ev), .power_good(pg), .host_alert(alert),
      .power_good_threshold(cfg[0]), .turn_on_delay(cfg[1]), .turn_on_rise_time(cfg[2]),
      .turn_off_delay(cfg[3]), .turn_off_fall_time(cfg[4]));

   psr_host host_u (
      .lk_clk(lk_clk), .lk_req(lk_req), .lk_acc(lk_acc), .lk_busy(lk_busy),
      .lk_done(lk_done), .lk_rdata(lk_rdata));

   // =====================================================================
   // checking helpers
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic w, input logic [7:0] c, input logic [15:0] d,
                      input bit dup = 1'b0);
      bit ok;
      host_u.access(w, c, d, dup, q, ok);
      chk(16'(ok), 16'h0001);
   endtask

   task automatic rd(input logic [7:0] c, input logic [15:0] e);
      acc(1'b0, c, 16'h0000);
      chk(q, e);
   endtask

   // live bits follow power good and the powered input, never sticky
   function automatic logic [15:0] live();
      return (exp_pg ? 16'h0000 : 16'h0800) | (powered ? 16'h0000 : 16'h0040);
   endfunction

   task automatic pulse(input int i);
      psr_pkg::psr_event_s e;
      e = '0;
      e[i] = 1'b1;
      @(posedge clk);
      ev <= e;
      @(posedge clk);
      ev <= '0;
      repeat (4) @(posedge clk);
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         $display("[ERR] %0t run did not finish", $time);
         conclude();
      end
   end

   // =====================================================================
   // scenarios
   initial begin
      strap = 16'h0100 | (16'($random(seed)) & 16'h3FFF);
      thr = int'(strap) * 9 / 10;
      pv = '{thr + 1, thr - 1, thr / 2 - 1};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      uvl <= 16'(thr / 2);
      repeat (5) @(posedge lk_clk);
      lk_rst <= 1'b0;
      repeat (4) @(posedge clk);
      for (int i = 0; i < 5; i++)
         rd(psr_pkg::CFG_CMD[i], (i == 0) ? 16'(thr) : psr_pkg::CFG_RESET[i]);
      rd(8'h78, 16'h0000);
      for (int i = 0; i < 4; i++)
         rd(8'h79 + 8'(i), (i == 0) ? live() : 16'h0000);
      $display("reset values done");
      for (int k = 0; k < 3; k++) begin
         @(posedge clk);
         vcode <= 16'(pv[k]);
         exp_pg = (k < 2);
         repeat (5) @(posedge clk);
         chk(16'(pg), 16'(exp_pg));
         rd(psr_pkg::CMD_STATUS_WORD, live());
      end
      // park the output low so random threshold writes cannot raise power good
      @(posedge clk);
      vcode <= 16'h0000;
      $display("power good done");
      for (int i = 0; i < 5; i++) begin
         v = 16'($random(seed));
         acc(1'b1, psr_pkg::CFG_CMD[i], v);
         chk(q, 16'h0000);
         rd(psr_pkg::CFG_CMD[i], v);
         chk(cfg[i], v);
      end
      $display("config words done");
      for (int k = 0; k < 11; k++) begin
         pulse(ix[k]);
         chk(16'(alert), 16'h0001);
         acc(1'b0, psr_pkg::CMD_STATUS_WORD, 16'h0000);
         chk(q & (k > 6 ? 16'hFFFE : 16'hFFFF), wd[k] | live());
         rd(dc[k], dv[k]);
         acc(1'b1, psr_pkg::CMD_CLEAR_FAULTS, 16'h0000);
         rd(psr_pkg::CMD_STATUS_WORD, live());
         chk(16'(alert), 16'h0000);
      end
      $display("status events done");
      acc(1'b1, psr_pkg::CMD_OUTPUT_VOLTAGE_STATUS, 16'hFFFF);
      rd(psr_pkg::CMD_OUTPUT_VOLTAGE_STATUS, 16'h0000);
      rd(psr_pkg::CMD_STATUS_WORD, 16'h0002 | live());
      acc(1'b1, psr_pkg::CMD_CLEAR_FAULTS, 16'h0000);
      acc(1'b0, psr_pkg::CMD_STATUS_WORD, 16'h0000, 1'b1);
      rd(psr_pkg::CMD_STATUS_BYTE, 16'h0080);
      acc(1'b1, psr_pkg::CMD_CLEAR_FAULTS, 16'h0000);
      @(posedge clk);
      powered <= 1'b0;
      repeat (3) @(posedge clk);
      rd(psr_pkg::CMD_STATUS_WORD, live());
      $display("refusals and off done");
      conclude();
   end
endmodule

`default_nettype wire
